// ### ocs_top.sv
// How it works
// - main source from read-only option field
// - code 01 internal, bus clock out
// - code 10 rc, bus clock out
// - code 11 crystal, inverting amp out
// - timebase source 00 int 01 rc 10 xtal
// - rc/xtal timebase only if main
// - rc and crystal never both enabled
// - internal oscillator runs after any reset
// - internal stops in stop only if disabled
// - watchdog always uses internal clock
// - main clock feeds generator and subsystems
// - stop kills rc/xtal unless keep bit
// - wait mode leaves all outputs running
// - system enable gates rc/xtal enables and internal main clock
// - break state keeps main clock running
`timescale 1ns/1ps
`default_nettype none
`include "ocs_map.svh"
module ocs_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  // option word from non-volatile storage
  input wire logic [7:0] nonvolatile_option,
  // system integration module
  input wire logic osc_enable_from_sysint,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic break_state,
  input wire logic bus_clock,
  // oscillator clocks (sampled)
  input wire logic internal_osc_clock,
  input wire logic rc_osc_clock,
  input wire logic crystal_osc_clock,
  input wire logic crystal_amp_out,
  // oscillator enables
  output logic internal_osc_en,
  output logic rc_osc_en,
  output logic crystal_osc_en,
  // clock outputs
  output logic main_ref_clock,
  output logic pll_ref_clock,
  output logic timebase_ref_clock,
  output logic watchdog_ref_clock,
  output logic osc_output_pin,
  output logic osc_output_pin_oe,
  // status
  output logic pll_ref_unsuitable,
  output logic tb_source_unavailable
);
  logic rst_meta_reg;
  logic rst_n;
  logic [7:0] tb_cfg_reg;
  logic [7:0] opt_reg;
  logic opt_loaded_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic [3:0] clk_sync;
  logic [2:0] ctl_sync;
  logic [7:0] opt_sync;
  logic [2:0] stop_latch_reg;
  ocs_pkg::ocs_mode_e mode_reg;
  ocs_pkg::ocs_main_e main_sel;
  ocs_pkg::ocs_tb_e tb_sel;
  logic sysen;
  logic sel_int;
  logic sel_rc;
  logic sel_xtal;
  logic req;
  logic hit;
  logic wr_take;
  logic in_stop;
  logic [1:0] opt_wait_reg;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // an external source survives stop only when its keep bit was set
  function automatic logic ext_osc_on(
    input logic chosen,
    input logic keep,
    input logic in_stop_now
  );
    ext_osc_on = chosen && (!in_stop_now || keep);
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // oscillators are far slower than clk, so sampled copies suffice
  ocs_sync #(.W(4)) u_clk_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({crystal_amp_out, crystal_osc_clock, rc_osc_clock, internal_osc_clock}),
    .q(clk_sync)
  );

  ocs_sync #(.W(3)) u_ctl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({break_state, stop_mode, osc_enable_from_sysint}),
    .q(ctl_sync)
  );

  ocs_sync #(.W(8)) u_opt_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(nonvolatile_option),
    .q(opt_sync)
  );

  // ---------------------------------------------------------------
  // option capture after reset
  // ---------------------------------------------------------------
  // the synchroniser restarts with reset, so its output lags the release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      opt_wait_reg <= 2'h0;
    else if (opt_wait_reg != `OCS_OPT_SETTLE)
      opt_wait_reg <= opt_wait_reg + 2'h1;
  end

  // captured once; never writable at run time
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt_reg <= 8'h00;
      opt_loaded_reg <= 1'b0;
    end
    else if (!opt_loaded_reg && opt_wait_reg == `OCS_OPT_SETTLE)
    begin
      opt_reg <= opt_sync;
      opt_loaded_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  assign req = (avs_read || avs_write) && !ack_reg;
  assign hit = (avs_address == `OCS_ADDR_TB_CFG) || (avs_address == `OCS_ADDR_NV_OPT)
    || (avs_address == `OCS_ADDR_STATUS);
  // writes land on the accepting edge, when waitrequest is already low
  assign wr_take = avs_write && ack_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tb_cfg_reg <= `OCS_TB_CFG_RST;
    else if (wr_take && avs_address == `OCS_ADDR_TB_CFG && avs_byteenable[0])
      tb_cfg_reg <= {3'h0, avs_writedata[4:0]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end
    else if (req)
    begin
      err_reg <= !hit;
      rdata_reg <= 32'h0000_0000;
      if (avs_read)
      begin
        unique case (avs_address)
          `OCS_ADDR_TB_CFG: rdata_reg <= {24'h000000, tb_cfg_reg};
          `OCS_ADDR_NV_OPT: rdata_reg <= {24'h000000, opt_reg};
          `OCS_ADDR_STATUS: rdata_reg <= {24'h000000, ctl_sync[2], mode_reg,
            tb_source_unavailable, crystal_osc_en, rc_osc_en, internal_osc_en};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign avs_response_err = err_reg;

  // ---------------------------------------------------------------
  // power mode tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= ocs_pkg::OCS_RUN;
    else if (ctl_sync[1])
      mode_reg <= ocs_pkg::OCS_STOP;
    else if (wait_mode)
      mode_reg <= ocs_pkg::OCS_WAIT;
    else
      mode_reg <= ocs_pkg::OCS_RUN;
  end

  // keep bits frozen on stop entry, so late writes cannot matter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stop_latch_reg <= 3'h0;
    else if (!in_stop)
      stop_latch_reg <= {tb_cfg_reg[`OCS_STOP_XTAL_KEEP], tb_cfg_reg[`OCS_STOP_RC_KEEP],
        tb_cfg_reg[`OCS_STOP_INT_DIS]};
  end

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  assign main_sel = ocs_pkg::ocs_main_e'({opt_reg[`OCS_MAIN_SEL_HI],
    opt_reg[`OCS_MAIN_SEL_LO]});
  assign tb_sel = ocs_pkg::ocs_tb_e'({tb_cfg_reg[`OCS_TB_SEL_HI],
    tb_cfg_reg[`OCS_TB_SEL_LO]});
  assign sysen = ctl_sync[0];
  assign in_stop = mode_reg == ocs_pkg::OCS_STOP;

  assign sel_int = main_sel == ocs_pkg::OCS_MAIN_INT;
  assign sel_rc = main_sel == ocs_pkg::OCS_MAIN_RC;
  assign sel_xtal = main_sel == ocs_pkg::OCS_MAIN_XTAL;

  // ---------------------------------------------------------------
  // oscillator enables
  // ---------------------------------------------------------------
  // break and wait do not touch the enables
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      internal_osc_en <= 1'b1;
      rc_osc_en <= 1'b0;
      crystal_osc_en <= 1'b0;
    end
    else
    begin
      internal_osc_en <= !(in_stop && stop_latch_reg[0]);
      rc_osc_en <= sysen && opt_loaded_reg
        && ext_osc_on(sel_rc, stop_latch_reg[1], in_stop);
      crystal_osc_en <= sysen && opt_loaded_reg
        && ext_osc_on(sel_xtal, stop_latch_reg[2], in_stop);
    end
  end

  // ---------------------------------------------------------------
  // clock outputs
  // ---------------------------------------------------------------
  // watchdog reference ignores every selection and mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      watchdog_ref_clock <= 1'b0;
    else
      watchdog_ref_clock <= clk_sync[0];
  end

  // second pin: amplifier output in crystal mode, bus clock otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_output_pin <= 1'b0;
    else if (sel_xtal)
      osc_output_pin <= clk_sync[3];
    else
      osc_output_pin <= bus_clock;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_ref_clock <= 1'b0;
      timebase_ref_clock <= 1'b0;
      tb_source_unavailable <= 1'b0;
    end
    else
    begin
      unique case (main_sel)
        ocs_pkg::OCS_MAIN_INT: main_ref_clock <= clk_sync[0] && internal_osc_en && sysen;
        ocs_pkg::OCS_MAIN_RC: main_ref_clock <= clk_sync[1] && rc_osc_en;
        ocs_pkg::OCS_MAIN_XTAL: main_ref_clock <= clk_sync[2] && crystal_osc_en;
        ocs_pkg::OCS_MAIN_NONE: main_ref_clock <= 1'b0;
      endcase
      tb_source_unavailable <= 1'b0;
      unique case (tb_sel)
        ocs_pkg::OCS_TB_INT: timebase_ref_clock <= clk_sync[0] && internal_osc_en;
        ocs_pkg::OCS_TB_RC:
        begin
          timebase_ref_clock <= clk_sync[1] && rc_osc_en && sel_rc;
          tb_source_unavailable <= !sel_rc;
        end
        ocs_pkg::OCS_TB_XTAL:
        begin
          timebase_ref_clock <= clk_sync[2] && crystal_osc_en && sel_xtal;
          tb_source_unavailable <= !sel_xtal;
        end
        ocs_pkg::OCS_TB_NONE:
        begin
          timebase_ref_clock <= 1'b0;
          tb_source_unavailable <= 1'b1;
        end
      endcase
    end
  end

  assign pll_ref_clock = main_ref_clock;
  assign osc_output_pin_oe = 1'b1;
  // flags the unsuitable setup so software can avoid it
  assign pll_ref_unsuitable = sel_int;
endmodule
`default_nettype wire

// ### ocs_map.svh
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH
// register byte addresses on the avalon slave
`define OCS_ADDR_TB_CFG 4'h4
`define OCS_ADDR_NV_OPT 4'h8
`define OCS_ADDR_CTRL 4'h0
`define OCS_ADDR_STATUS 4'hC
// printed indices of the two documented registers
`define OCS_IDX_TB_CFG 16'h001D
`define OCS_IDX_NV_OPT 16'hFFCF
// field positions in timebase_config_two
`define OCS_TB_SEL_LO 0
`define OCS_TB_SEL_HI 1
`define OCS_STOP_INT_DIS 2
`define OCS_STOP_RC_KEEP 3
`define OCS_STOP_XTAL_KEEP 4
// field positions in nonvolatile_option
`define OCS_MAIN_SEL_LO 0
`define OCS_MAIN_SEL_HI 1
// reset values
`define OCS_TB_CFG_RST 8'h00
`define OCS_CTRL_RST 8'h00
// edges the option synchroniser needs before its output is trusted
`define OCS_OPT_SETTLE 2'h2
`endif

// ### ocs_pkg.sv
package ocs_pkg;
  typedef enum logic [1:0] {
    OCS_MAIN_NONE = 2'h0,
    OCS_MAIN_INT = 2'h1,
    OCS_MAIN_RC = 2'h2,
    OCS_MAIN_XTAL = 2'h3
  } ocs_main_e;
  typedef enum logic [1:0] {
    OCS_TB_INT = 2'h0,
    OCS_TB_RC = 2'h1,
    OCS_TB_XTAL = 2'h2,
    OCS_TB_NONE = 2'h3
  } ocs_tb_e;
  typedef enum logic [2:0] {
    OCS_RUN = 3'h1,
    OCS_WAIT = 3'h2,
    OCS_STOP = 3'h4
  } ocs_mode_e;
endpackage

// ### ocs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### ocs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // selection and modes
  input wire logic [7:0] nonvolatile_option,
  input wire logic osc_enable_from_sysint,
  input wire logic stop_mode,
  // oscillators
  input wire logic internal_osc_clock,
  input wire logic internal_osc_en,
  input wire logic rc_osc_en,
  input wire logic crystal_osc_en,
  input wire logic main_ref_clock,
  input wire logic pll_ref_clock,
  input wire logic watchdog_ref_clock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer took more than one wait cycle");
  a_shared_pin: assert property (!(rc_osc_en && crystal_osc_en))
    else $error("rc and crystal enabled together");
  a_rc_needs_main: assert property (rc_osc_en |-> nonvolatile_option[1:0] == 2'h2)
    else $error("rc enabled while not main source");
  a_xtal_needs_main: assert property (crystal_osc_en |-> nonvolatile_option[1:0] == 2'h3)
    else $error("crystal enabled while not main source");
  a_int_runs: assert property (!stop_mode [*5] |-> internal_osc_en)
    else $error("internal oscillator off outside stop");
  a_pll_buffered: assert property (pll_ref_clock == main_ref_clock)
    else $error("pll reference differs from main clock");
  a_sysint_gate: assert property (!osc_enable_from_sysint [*5] |-> !rc_osc_en && !crystal_osc_en)
    else $error("external oscillator on while system enable low");
  a_wdog_internal_osc_clock: assert property ($changed(watchdog_ref_clock) |->
    watchdog_ref_clock == $past(internal_osc_clock, 2) ||
    watchdog_ref_clock == $past(internal_osc_clock, 3) ||
    watchdog_ref_clock == $past(internal_osc_clock, 4))
    else $error("watchdog clock not from internal oscillator");
endmodule
bind ocs_top ocs_chk i_chk (.*);
`default_nettype wire

// ### ocs_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_osc_model (
  // clock
  input wire logic clk,
  // enables from the block
  input wire logic internal_osc_en,
  input wire logic rc_osc_en,
  input wire logic crystal_osc_en,
  // oscillator outputs
  output logic internal_osc_clock,
  output logic rc_osc_clock,
  output logic crystal_osc_clock,
  output logic crystal_amp_out
);
  logic [4:0] cnt_reg = 5'h00;
  always_ff @(posedge clk) cnt_reg <= cnt_reg + 5'h01;
  // a stopped oscillator freezes low
  assign internal_osc_clock = internal_osc_en & cnt_reg[3];
  assign rc_osc_clock = rc_osc_en & cnt_reg[2];
  assign crystal_osc_clock = crystal_osc_en & cnt_reg[4];
  // unpowered amplifier output wanders, never a stable level
  assign crystal_amp_out = crystal_osc_en ? ~cnt_reg[4] : cnt_reg[0];
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocs_map.svh"
module tb;
  logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, avs_response_err, er;
  logic [7:0] nonvolatile_option = 8'h01;
  logic osc_enable_from_sysint = 1'b1, stop_mode = 1'b0, wait_mode = 1'b0;
  logic break_state = 1'b0, bus_clock = 1'b0;
  logic internal_osc_clock, rc_osc_clock, crystal_osc_clock, crystal_amp_out;
  logic internal_osc_en, rc_osc_en, crystal_osc_en, main_ref_clock, pll_ref_clock;
  logic timebase_ref_clock, watchdog_ref_clock, osc_output_pin, osc_output_pin_oe;
  logic pll_ref_unsuitable, tb_source_unavailable;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  int n_main = 0, n_tbc = 0, n_wd = 0, snap = 0;
  logic lv;
  initial forever #12.5 clk = ~clk;
  ocs_top i_dut (.*);
  ocs_osc_model i_osc (.*);
  // edge counters show whether a clock output runs
  always @(main_ref_clock) n_main++;
  always @(timebase_ref_clock) n_tbc++;
  always @(watchdog_ref_clock) n_wd++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // hold the request until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    er = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task restart(input logic [7:0] opt);
    @(posedge clk);
    reset_n <= 1'b0;
    nonvolatile_option <= opt;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_select;
    for (int m = 0; m < 4; m++)
    begin
      restart(8'(m));
      chk("int_en", internal_osc_en, 1);
      chk("rc_en", rc_osc_en, m == 2);
      chk("xtal_en", crystal_osc_en, m == 3);
      chk("unsuit", pll_ref_unsuitable, m == 1);
      chk("osc_output_pin_oe", osc_output_pin_oe, 1);
      snap = n_main;
      settle(40);
      chk("main_run", n_main != snap, m != 0);
      bus(0, `OCS_ADDR_TB_CFG, 0);
      chk("cfg_rst", rd, `OCS_TB_CFG_RST);
      bus(0, `OCS_ADDR_NV_OPT, 0);
      chk("nv_opt", rd, m);
      bus(1, `OCS_ADDR_NV_OPT, 32'hFF);
      bus(0, `OCS_ADDR_NV_OPT, 0);
      chk("nv_ro", rd, m);
      if (m != 3)
      begin
        bus_clock <= 1'b1;
        settle(8);
        chk("osc_output_pin_hi", osc_output_pin, 1);
        bus_clock <= 1'b0;
        settle(8);
        chk("osc_output_pin_lo", osc_output_pin, 0);
      end
      else
      begin
        lv = crystal_osc_clock;
        while (crystal_osc_clock === lv) @(posedge clk);
        settle(8);
        chk("osc_output_pin_amp", osc_output_pin, !crystal_osc_clock);
      end
    end
  endtask
  task s_timebase;
    for (int s = 0; s < 4; s++)
    begin
      bus(1, `OCS_ADDR_TB_CFG, s);
      bus(0, `OCS_ADDR_TB_CFG, 0);
      chk("tb_cfg", rd, s);
      settle(4);
      chk("tb_unav", tb_source_unavailable, s == 1 || s == 3);
      snap = n_tbc;
      settle(40);
      chk("tb_run", n_tbc != snap, s == 0 || s == 2);
    end
  endtask
  task s_modes;
    bus(1, `OCS_ADDR_TB_CFG, 0);
    stop_mode <= 1'b1;
    settle(8);
    chk("stop_xtal", crystal_osc_en, 0);
    chk("stop_int", internal_osc_en, 1);
    snap = n_wd;
    settle(40);
    chk("wd_stop", n_wd != snap, 1);
    bus(0, `OCS_ADDR_STATUS, 0);
    chk("mode_stop", rd[6:4], 3'h4);
    stop_mode <= 1'b0;
    settle(8);
    bus(1, `OCS_ADDR_TB_CFG, 32'h14);
    stop_mode <= 1'b1;
    settle(8);
    chk("keep_xtal", crystal_osc_en, 1);
    chk("dis_int", internal_osc_en, 0);
    snap = n_wd;
    settle(20);
    chk("wd_off", n_wd != snap, 0);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    settle(8);
    chk("wait_xtal", crystal_osc_en, 1);
    bus(0, `OCS_ADDR_STATUS, 0);
    chk("mode_wait", rd[6:4], 3'h2);
    snap = n_main;
    settle(40);
    chk("wait_main", n_main != snap, 1);
    wait_mode <= 1'b0;
    break_state <= 1'b1;
    settle(8);
    chk("brk_xtal", crystal_osc_en, 1);
    bus(0, `OCS_ADDR_STATUS, 0);
    chk("brk_seen", rd[7], 1);
    snap = n_main;
    settle(40);
    chk("brk_main", n_main != snap, 1);
    break_state <= 1'b0;
    osc_enable_from_sysint <= 1'b0;
    settle(8);
    chk("sys_off", crystal_osc_en, 0);
    osc_enable_from_sysint <= 1'b1;
    settle(8);
    chk("sys_on", crystal_osc_en, 1);
  endtask
  task s_unmapped;
    bus(1, `OCS_ADDR_CTRL, 32'hFF);
    chk("wr_err", er, 1);
    bus(0, `OCS_ADDR_CTRL, 0);
    chk("rd_err", er, 1);
    chk("rd_zero", rd, 0);
    bus(0, `OCS_ADDR_NV_OPT, 0);
    chk("ok_err", er, 0);
  endtask
  initial
  begin
    s_select();
    s_timebase();
    s_modes();
    s_unmapped();
    final_report();
  end
endmodule
`default_nettype wire
